// ### hw/bk7_ctrl.sv
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bk7_ctrl
    import bk7_pkg::*;
#(
    parameter int DISCHARGE_CYC = BK7_DISCHARGE_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // otp and system
    input wire logic [BK7_VW-1:0] otp_buck7_voltage_default,
    input wire logic [1:0] otp_buck7_inductor_sel,
    input wire logic otp_in_sequence,
    input wire logic standby_req,
    // power stage
    output logic buck7_enable,
    output logic buck7_discharge,
    output logic [BK7_MW-1:0] buck7_mode_code,
    output logic [8:0] buck7_set_point_10mv,
    output logic [BK7_IW-1:0] buck7_current_limit_sel,
    output logic [BK7_PW-1:0] buck7_phase_sel,
    output logic [1:0] buck7_inductor_sel,
    output logic buck7_inductor_invalid,
    // interrupt
    output logic irq_out_n
);
    ////////////////////////////////////////////////////////////////
    // standby input synchroniser
    logic [2:0] sby_sync_q, sby_sync_d;
    logic standby_q, standby_d;

    always_comb begin
        sby_sync_d = {sby_sync_q[1:0], standby_req};
        standby_d = standby_q;
        if (sby_sync_q[1] == sby_sync_q[2]) begin
            standby_d = sby_sync_q[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sby_sync_q <= 3'h0;
            standby_q <= 1'b0;
        end else if (clk_en) begin
            sby_sync_q <= sby_sync_d;
            standby_q <= standby_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture
    logic wr_pend_q, wr_pend_d;
    logic rd_pend_q, rd_pend_d;
    logic [7:0] addr_q, addr_d;
    logic take;

    assign take = hsel && hready && (htrans == BK7_HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        wr_pend_d = take && hwrite;
        rd_pend_d = take && !hwrite;
        addr_d = take ? haddr : addr_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (clk_en) begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q <= addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // configuration registers
    logic init_q, init_d;
    logic [BK7_VW-1:0] volt_q, volt_d;
    logic [BK7_MW-1:0] run_q, run_d, sby_q, sby_d;
    logic [BK7_IW-1:0] ilim_q, ilim_d;
    logic [BK7_PW-1:0] phase_q, phase_d;
    logic [1:0] ind_q, ind_d;
    logic mask_q, mask_d;
    logic flag_q, flag_d;
    logic volt_chg;
    logic mode_chg;
    logic [BK7_MW-1:0] eff_mode, last_mode_q, last_mode_d;
    bk7_state_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] rdata_d;
    logic [31:0] hrdata_d;
    logic irq_n_d;
    logic [8:0] set_point_d;

    always_comb begin
        init_d = 1'b1;
        volt_d = volt_q;
        run_d = run_q;
        sby_d = sby_q;
        ilim_d = ilim_q;
        phase_d = phase_q;
        ind_d = ind_q;
        mask_d = mask_q;
        volt_chg = 1'b0;
        if (!init_q) begin
            volt_d = otp_buck7_voltage_default;
            ind_d = otp_buck7_inductor_sel;
            run_d = otp_in_sequence ? BK7_MODE_SEQ : BK7_MODE_NOSEQ;
            sby_d = otp_in_sequence ? BK7_MODE_SEQ : BK7_MODE_NOSEQ;
        end else if (wr_pend_q) begin
            unique case (addr_q)
                BK7_OFF_VOLT: begin
                    volt_d = hwdata[BK7_VW-1:0];
                    volt_chg = (hwdata[BK7_VW-1:0] != volt_q);
                end
                BK7_OFF_MODE: begin
                    run_d = hwdata[BK7_MW-1:0];
                    sby_d = hwdata[BK7_MODE_STBY_LSB +: BK7_MW];
                end
                BK7_OFF_CFG: begin
                    ilim_d = hwdata[BK7_IW-1:0];
                    phase_d = hwdata[BK7_CFG_PH_LSB +: BK7_PW];
                end
                BK7_OFF_IRQ: mask_d = hwdata[BK7_IRQ_MASK_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_q <= 1'b0;
            volt_q <= '0;
            run_q <= BK7_MODE_NOSEQ;
            sby_q <= BK7_MODE_NOSEQ;
            ilim_q <= BK7_ILIM_RST;
            phase_q <= BK7_PHASE_ZERO;
            ind_q <= BK7_IND_RSVD;
            mask_q <= 1'b0;
        end else if (clk_en) begin
            init_q <= init_d;
            volt_q <= volt_d;
            run_q <= run_d;
            sby_q <= sby_d;
            ilim_q <= ilim_d;
            phase_q <= phase_d;
            ind_q <= ind_d;
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // enable sequencer: discharge then re-enable on voltage change
    // voltage unaffected by standby; only selector picks mode
    assign eff_mode = standby_q ? sby_q : run_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            BK7_ST_ON: begin
                if (volt_chg && eff_mode != BK7_MODE_OFF) begin
                    st_d = BK7_ST_DISCH;
                    cnt_d = 32'(DISCHARGE_CYC - 1);
                end
            end
            BK7_ST_DISCH: begin
                if (cnt_q == 32'h0) begin
                    st_d = BK7_ST_OFF;
                end else begin
                    cnt_d = cnt_q - 32'h1;
                end
            end
            BK7_ST_OFF: st_d = BK7_ST_ON;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= BK7_ST_ON;
            cnt_q <= 32'h0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode-change interrupt; set wins over clear
    assign mode_chg = init_q && (eff_mode != last_mode_q);

    always_comb begin
        // seed with the loaded selector: power-up load raises no flag
        last_mode_d = init_q ? eff_mode : run_d;
        flag_d = flag_q;
        if (wr_pend_q && addr_q == BK7_OFF_IRQ && hwdata[BK7_IRQ_FLAG_BIT]) begin
            flag_d = 1'b0;
        end
        if (mode_chg) begin
            flag_d = 1'b1;
        end
        irq_n_d = !(flag_d && !mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_mode_q <= BK7_MODE_OFF;
            flag_q <= 1'b0;
            irq_out_n <= 1'b1;
        end else if (clk_en) begin
            last_mode_q <= last_mode_d;
            flag_q <= flag_d;
            irq_out_n <= irq_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power stage outputs
    bk7_vtable u_vtable (
        .code(volt_q),
        .set_point_10mv(set_point_d)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buck7_set_point_10mv <= BK7_SP_RST;
        end else if (clk_en) begin
            buck7_set_point_10mv <= set_point_d;
        end
    end

    assign buck7_mode_code = (st_q == BK7_ST_ON) ? eff_mode : BK7_MODE_OFF;
    assign buck7_enable = (st_q == BK7_ST_ON) && (eff_mode != BK7_MODE_OFF);
    assign buck7_discharge = (st_q == BK7_ST_DISCH);
    assign buck7_current_limit_sel = ilim_q;
    assign buck7_phase_sel = phase_q;
    assign buck7_inductor_sel = ind_q;
    assign buck7_inductor_invalid = (ind_q == BK7_IND_RSVD);

    ////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        rdata_d = 32'h0;
        unique case (addr_d)
            BK7_OFF_VOLT: rdata_d[BK7_VW-1:0] = volt_q;
            BK7_OFF_MODE: rdata_d[2*BK7_MW-1:0] = {sby_q, run_q};
            BK7_OFF_CFG: rdata_d[BK7_CFG_PH_LSB+BK7_PW-1:0] = {phase_q, ilim_q};
            BK7_OFF_STAT: begin
                rdata_d[BK7_MW-1:0] = buck7_mode_code;
                rdata_d[BK7_STAT_STBY_BIT] = standby_q;
                rdata_d[BK7_STAT_BUSY_BIT] = (st_q != BK7_ST_ON);
                rdata_d[BK7_STAT_IND_LSB +: 2] = ind_q;
                rdata_d[BK7_STAT_VOLT_LSB +: 9] = set_point_d;
            end
            BK7_OFF_IRQ: rdata_d[1:0] = {mask_q, flag_q};
            default: ;
        endcase
        hrdata_d = hrdata;
        if (take && !hwrite) begin
            hrdata_d = rdata_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (clk_en) begin
            hrdata <= hrdata_d;
        end
    end
endmodule
`default_nettype wire

// ### hw/bk7_pkg.sv
package bk7_pkg;
    // register byte offsets
    localparam logic [7:0] BK7_OFF_VOLT = 8'h00;
    localparam logic [7:0] BK7_OFF_MODE = 8'h04;
    localparam logic [7:0] BK7_OFF_CFG = 8'h08;
    localparam logic [7:0] BK7_OFF_STAT = 8'h0c;
    localparam logic [7:0] BK7_OFF_IRQ = 8'h10;
    // field widths
    localparam int BK7_VW = 5;
    localparam int BK7_MW = 2;
    localparam int BK7_IW = 2;
    localparam int BK7_PW = 3;
    // field positions
    localparam int BK7_MODE_STBY_LSB = 2;
    localparam int BK7_CFG_PH_LSB = 2;
    localparam int BK7_STAT_STBY_BIT = 2;
    localparam int BK7_STAT_BUSY_BIT = 3;
    localparam int BK7_STAT_IND_LSB = 4;
    localparam int BK7_STAT_VOLT_LSB = 8;
    localparam int BK7_IRQ_MASK_BIT = 1;
    localparam int BK7_IRQ_FLAG_BIT = 0;
    // reset values
    localparam logic [1:0] BK7_MODE_SEQ = 2'h3;
    localparam logic [1:0] BK7_MODE_NOSEQ = 2'h0;
    localparam logic [2:0] BK7_PHASE_ZERO = 3'h7;
    localparam logic [1:0] BK7_ILIM_RST = 2'h0;
    localparam logic [1:0] BK7_IND_RSVD = 2'h3;
    localparam logic [8:0] BK7_SP_RST = 9'h064;
    // mode codes
    localparam logic [1:0] BK7_MODE_OFF = 2'h0;
    localparam logic [1:0] BK7_MODE_PWM = 2'h1;
    localparam logic [1:0] BK7_MODE_PFM = 2'h2;
    localparam logic [1:0] BK7_MODE_AUTO = 2'h3;
    // discharge time before re-enable
    localparam int BK7_CLK_MHZ = 25;
    localparam int BK7_DISCHARGE_US = 200;
    localparam int BK7_DISCHARGE_CYC = BK7_DISCHARGE_US * BK7_CLK_MHZ;
    localparam logic [1:0] BK7_HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {BK7_ST_ON, BK7_ST_DISCH, BK7_ST_OFF} bk7_state_e;
endpackage

// ### hw/bk7_vtable.sv
`timescale 1ns/10ps
`default_nettype none
// code to set point in tens of millivolts
module bk7_vtable
    import bk7_pkg::*;
(
    // code in
    input wire logic [BK7_VW-1:0] code,
    // set point out
    output logic [8:0] set_point_10mv
);
    always_comb begin
        unique case (code)
            5'h00: set_point_10mv = 9'd100;
            5'h01: set_point_10mv = 9'd110;
            5'h02: set_point_10mv = 9'd120;
            5'h03: set_point_10mv = 9'd125;
            5'h04: set_point_10mv = 9'd130;
            5'h05: set_point_10mv = 9'd135;
            5'h06: set_point_10mv = 9'd150;
            5'h07: set_point_10mv = 9'd160;
            5'h08: set_point_10mv = 9'd180;
            5'h09: set_point_10mv = 9'd185;
            5'h0a: set_point_10mv = 9'd200;
            5'h0b: set_point_10mv = 9'd210;
            5'h0c: set_point_10mv = 9'd215;
            5'h0d: set_point_10mv = 9'd225;
            5'h0e: set_point_10mv = 9'd230;
            5'h0f: set_point_10mv = 9'd240;
            5'h10: set_point_10mv = 9'd250;
            5'h11: set_point_10mv = 9'd280;
            5'h12: set_point_10mv = 9'd315;
            5'h13: set_point_10mv = 9'd320;
            5'h14: set_point_10mv = 9'd325;
            5'h15: set_point_10mv = 9'd330;
            5'h16: set_point_10mv = 9'd335;
            5'h17: set_point_10mv = 9'd340;
            5'h18: set_point_10mv = 9'd350;
            5'h19: set_point_10mv = 9'd380;
            5'h1a: set_point_10mv = 9'd400;
            default: set_point_10mv = 9'd410;
        endcase
    end
endmodule
`default_nettype wire

// ### verif/bk7_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module bk7_ctrl_checker #(
    parameter int DISCHARGE_CYC = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // power stage
    input wire logic buck7_enable,
    input wire logic buck7_discharge,
    input wire logic [1:0] buck7_mode_code,
    input wire logic [8:0] buck7_set_point_10mv,
    input wire logic [1:0] buck7_current_limit_sel,
    input wire logic [2:0] buck7_phase_sel,
    input wire logic [1:0] buck7_inductor_sel,
    input wire logic buck7_inductor_invalid,
    // interrupt
    input wire logic irq_out_n
);
    logic [15:0] dc_q, dc_d;
    logic [1:0] mc_q, mc_d;
    logic [2:0] ch_q, ch_d;
    // discharge length and recent mode changes
    always_comb begin
        dc_d = buck7_discharge ? dc_q + 16'h1 : 16'h0;
        mc_d = buck7_mode_code;
        ch_d = {ch_q[1:0], mc_q != buck7_mode_code};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dc_q <= 16'h0;
            mc_q <= 2'h0;
            ch_q <= 3'h0;
        end else begin
            dc_q <= dc_d;
            mc_q <= mc_d;
            ch_q <= ch_d;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence off_then_on;
        !buck7_enable ##1 buck7_enable;
    endsequence
    disch_off_a: assert property (
        buck7_discharge |-> !buck7_enable && buck7_mode_code == 2'h0)
        else $error("stage on while discharging");
    disch_len_a: assert property (
        $fell(buck7_discharge) |-> dc_q == DISCHARGE_CYC)
        else $error("discharge length wrong");
    reenable_a: assert property (
        $fell(buck7_discharge) |-> off_then_on)
        else $error("no re-enable after discharge");
    irq_cause_a: assert property (
        $fell(irq_out_n) |-> |ch_q)
        else $error("irq without mode change");
    rst_vals_a: assert property (
        $rose(hresetn) |-> buck7_phase_sel == 3'h7 && buck7_current_limit_sel == 2'h0 && irq_out_n)
        else $error("reset values wrong");
    ind_code_a: assert property (
        buck7_inductor_invalid == (buck7_inductor_sel == 2'h3))
        else $error("inductor invalid flag wrong");
    setpt_rng_a: assert property (
        buck7_set_point_10mv inside {[9'h064:9'h19a]})
        else $error("set point out of range");
    off_mode_a: assert property (
        buck7_mode_code == 2'h0 |-> !buck7_enable)
        else $error("enabled in off mode");
endmodule
bind bk7_ctrl bk7_ctrl_checker #(.DISCHARGE_CYC(DISCHARGE_CYC)) u_chk (.hclk, .hresetn,
    .buck7_enable, .buck7_discharge, .buck7_mode_code, .buck7_set_point_10mv,
    .buck7_current_limit_sel, .buck7_phase_sel, .buck7_inductor_sel,
    .buck7_inductor_invalid, .irq_out_n);
`default_nettype wire

// ### verif/bk7_host.sv
`timescale 1ns/10ps
`default_nettype none
module bk7_host (
    // clock and answer
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // request
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    // single word transfer; no path ever writes the inductor code
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        #1;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_buck7_regulator_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_buck7_regulator_control
    import bk7_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, seq = 1'b0, stby = 1'b0;
    logic hsel, hwrite, hrdy, en, dis, inv, irq, resp;
    logic [7:0] haddr;
    logic [1:0] htrans, mc, il, ind, otp_ind = 2'h0;
    logic [2:0] hsize, ph;
    logic [4:0] otp_v = 5'h0;
    logic [8:0] sp;
    logic [31:0] hwdata, hrdata, r;
    int err_count = 0, n_checks = 0, cyc = 0, seed = 83555, v, k, saw, m;
    int tbl[32] = '{100, 110, 120, 125, 130, 135, 150, 160, 180, 185, 200, 210, 215, 225,
        230, 240, 250, 280, 315, 320, 325, 330, 335, 340, 350, 380, 400, 410, 410, 410, 410, 410};
    always #20 hclk = ~hclk;
    bk7_host host (.hclk, .hready(hrdy), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata);
    bk7_ctrl #(.DISCHARGE_CYC(8)) dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hrdy), .hwdata, .hrdata, .hreadyout(hrdy),
        .hresp(resp), .otp_buck7_voltage_default(otp_v), .otp_buck7_inductor_sel(otp_ind),
        .otp_in_sequence(seq), .standby_req(stby), .buck7_enable(en),
        .buck7_discharge(dis), .buck7_mode_code(mc), .buck7_set_point_10mv(sp),
        .buck7_current_limit_sel(il), .buck7_phase_sel(ph), .buck7_inductor_sel(ind),
        .buck7_inductor_invalid(inv), .irq_out_n(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, r);
    endtask
    task rd(input logic [7:0] a);
        host.xfer(a, 1'b0, 32'h0, r);
    endtask
    task wait3;
        repeat (3) @(posedge hclk);
        #1;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 3; i >= 0; i--) begin
            @(posedge hclk);
            hresetn <= 1'b0;
            otp_ind <= 2'(i);
            seq <= i[0];
            otp_v <= 5'($random(seed));
            repeat (3) @(posedge hclk);
            hresetn <= 1'b1;
            wait3;
            m = i[0] ? 3 : 0;
            rd(BK7_OFF_MODE);
            chk("mode_rst", m | (m << BK7_MODE_STBY_LSB), r);
            rd(BK7_OFF_VOLT);
            chk("volt_rst", otp_v, r);
            rd(BK7_OFF_CFG);
            chk("cfg_rst", 32'h1c, r);
            rd(BK7_OFF_STAT);
            chk("stat_ind", i, r[5:4]);
            chk("ind", i, ind);
            chk("ind_inv", i == 3, inv);
            chk("sp_rst", tbl[otp_v], sp);
            chk("irq_rst", 1, irq);
            chk("hresp", 0, resp);
        end
        for (v = 0; v < 32; v++) begin
            wr(BK7_OFF_VOLT, v);
            wait3;
            chk("sp", tbl[v], sp);
        end
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20);
        chk("unmapped", 0, r);
        wr(BK7_OFF_IRQ, 1);
        for (k = 1; k < 5; k++) begin
            m = k % 4;
            wr(BK7_OFF_MODE, m);
            wait3;
            chk("mode", m, mc);
            chk("en", m != 0, en);
            chk("irq_n", 0, irq);
            rd(BK7_OFF_IRQ);
            chk("flag", 1, r[0]);
            wr(BK7_OFF_IRQ, 1);
            wait3;
            chk("irq_clr", 1, irq);
        end
        wr(BK7_OFF_IRQ, 2);
        wr(BK7_OFF_MODE, 1);
        wait3;
        chk("irq_masked", 1, irq);
        rd(BK7_OFF_IRQ);
        chk("flag_masked", 3, r[1:0]);
        wr(BK7_OFF_IRQ, 1);
        wr(BK7_OFF_VOLT, 5);
        rd(BK7_OFF_STAT);
        chk("stat_busy", (tbl[5] << BK7_STAT_VOLT_LSB) | (1 << BK7_STAT_BUSY_BIT), r);
        saw = 0;
        for (k = 0; k < 30 && !(saw && en); k++) begin
            @(posedge hclk);
            #1;
            if (dis)
                saw = 1;
        end
        chk("disch", 1, saw);
        chk("sp_new", tbl[5], sp);
        chk("en_back", 1, en);
        rd(BK7_OFF_STAT);
        chk("stat_on", (tbl[5] << BK7_STAT_VOLT_LSB) | 1, r);
        wr(BK7_OFF_MODE, 32'h9);
        @(posedge hclk);
        stby <= 1'b1;
        repeat (8) @(posedge hclk);
        #1;
        chk("stby_mode", 2, mc);
        chk("stby_sp", tbl[5], sp);
        chk("stby_dis", 0, dis);
        wr(BK7_OFF_MODE, 1);
        wait3;
        chk("stby_off", 0, en);
        @(posedge hclk);
        stby <= 1'b0;
        repeat (8) @(posedge hclk);
        #1;
        chk("run_back", 1, mc);
        chk("run_sp", tbl[5], sp);
        for (k = 0; k < 8; k++) begin
            v = $random(seed) & 3;
            wr(BK7_OFF_CFG, (k << BK7_CFG_PH_LSB) | v);
            chk("phase", k, ph);
            chk("ilim", v, il);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
